// ### hdl/sltc_top.sv
`timescale 1ns/1ps
//
// Contract
// [RL1] swap bit 1 exchanges A/B channel positions (the code uses bit 0, SWAP_BIT)
// [RL2] rate field 7:4, code 0011 = 13.5 Gbps
// [RL3] sticky loss-of-lock, cleared by 0x0571 bit0
// [RL4] standby select 0 sends zero samples
// [RL5] standby select 1 sends K28.5 repeats
// [RL6] test bit 5 sends long transport pattern
// [RL7] tail bits pseudorandom or fixed by bit6
// [RL8] link bit0: 0 enabled, 1 held reset
//
module sltc_top
  import sltc_pkg::*;
#(
  parameter int SAMPLE_W = 14
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sltc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter and pll side
  input wire logic [13:0] sample_a,
  input wire logic [13:0] sample_b,
  input wire logic sample_valid,
  input wire logic standby,
  input wire logic pll_locked_pin,
  input wire logic receiver_sync_request_input,
  // link side
  output sltc_pkg::sltc_word_t lane_a,
  output sltc_pkg::sltc_word_t lane_b,
  output logic lane_valid,
  output logic [3:0] lane_rate_code,
  output logic rate_13g5_sel,
  output logic link_reset,
  output logic irq
);
  import sltc_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] swap;
    logic [7:0] pll_ctrl;
    logic [7:0] link_ctrl;
    logic lol;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] lock_sync;
    logic [1:0] sync_sync;
    logic lock_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sltc_word_t lane_a;
    sltc_word_t lane_b;
    logic lane_valid;
    logic [3:0] rate;
    logic rate_13g5;
    logic link_reset;
    logic irq;
    logic [13:0] test_cnt;
  } sltc_st_t;

  sltc_st_t s_q, s_d;
  logic [1:0] pn_bits;
  logic pn_adv;
  logic acc, wr, rd;
  logic [31:0] rdat;
  logic hit;
  sltc_src_t src;

  // decode a word from its source
  function automatic sltc_word_t make_word(sltc_src_t kind, logic [13:0] smp, logic [13:0] tst,
                                            logic [1:0] tl);
    sltc_word_t w;
    w = '0;
    unique case (kind)
      SRC_DATA: w = '{sample: smp, tail: tl, is_k: 1'b0};
      SRC_ZERO: w = '{sample: 14'h0000, tail: tl, is_k: 1'b0};
      // control chars carry no tail bits
      SRC_CGS: w = '{sample: {6'h00, K28_5}, tail: 2'h0, is_k: 1'b1};
      SRC_TEST: w = '{sample: tst, tail: tl, is_k: 1'b0};
    endcase
    return w;
  endfunction : make_word

  // ----------------------------------------
  // pseudorandom tail source
  // ----------------------------------------
  // advance only on accepted samples; idle cycles do not use up pattern bits
  assign pn_adv = sample_valid & ~s_q.link_ctrl[LINK_OFF_BIT];
  sltc_pn u_pn (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .advance(pn_adv),
    .bits(pn_bits)
  );

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  // apb phase decode; zero wait states
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  // read data is captured in the setup cycle so it stands beside pready
  assign rd = psel & ~penable & ~pwrite;

  // read mux; unmapped reads zero with pslverr
  // reserved bits read back as zero, except link_ctrl bits 4:1, which are stored and read back as written
  always_comb begin
    rdat = 32'h0000_0000;
    hit = 1'b1;
    unique case (paddr)
      ADDR_SWAP: rdat = {24'h000000, s_q.swap};
      ADDR_PLL_CTRL: rdat = {24'h000000, s_q.pll_ctrl[7:4], 4'h0};
      ADDR_PLL_STAT: rdat = {24'h000000, s_q.lock_sync[1], 3'h0, s_q.lol, 3'h0};
      ADDR_LINK_CTRL1: rdat = {24'h000000, s_q.link_ctrl};
      ADDR_IRQ_STAT: rdat = {30'h0, s_q.irq_stat};
      ADDR_IRQ_MASK: rdat = {30'h0, s_q.irq_mask};
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // stream source select
  // ----------------------------------------
  // stream source priority: reset, test, standby, sync request, data
  always_comb begin
    if (s_q.link_ctrl[LTPL_BIT]) begin
      src = SRC_TEST; // [RL6]
    end else if (standby) begin
      src = s_q.link_ctrl[STBY_SEL_BIT] ? SRC_CGS : SRC_ZERO; // [RL4] [RL5]
    end else if (s_q.sync_sync[1] == 1'b0) begin
      src = SRC_CGS; // sync request low asks for code group sync
    end else begin
      src = SRC_DATA;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] tl;
    logic [13:0] a_s;
    logic [13:0] b_s;
    logic lol_set;
    logic [1:0] ev;
    tl = 2'h0;
    a_s = 14'h0000;
    b_s = 14'h0000;
    lol_set = 1'b0;
    ev = 2'h0;
    s_d = s_q;
    // lock and sync request pins cross two flops before use
    s_d.lock_sync = {s_q.lock_sync[0], pll_locked_pin};
    s_d.sync_sync = {s_q.sync_sync[0], receiver_sync_request_input};
    // edge detect reads the second flop only, never the metastable first one
    s_d.lock_prev = s_q.lock_sync[1];
    lol_set = s_q.lock_prev & ~s_q.lock_sync[1];
    ev[IRQ_LOL] = lol_set;
    ev[IRQ_LOCK] = ~s_q.lock_prev & s_q.lock_sync[1];
    s_d.pready = psel & ~penable; // ready in the access cycle
    s_d.pslverr = psel & ~penable & ~hit;
    // prdata holds between reads; only pready qualifies it
    if (rd) begin
      s_d.prdata = rdat;
    end
    if (wr) begin
      unique case (paddr)
        ADDR_SWAP: s_d.swap = {7'h00, pwdata[SWAP_BIT]};
        // reserved low nibble is never stored
        ADDR_PLL_CTRL: s_d.pll_ctrl = {pwdata[RATE_HI:RATE_LO], 4'h0}; // [RL2]
        ADDR_LINK_CTRL1: begin
          s_d.link_ctrl = pwdata[7:0];
          if (pwdata[LINK_OFF_BIT]) begin
            s_d.lol = 1'b0; // [RL3]
          end
        end
        ADDR_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~pwdata[1:0];
        ADDR_IRQ_MASK: s_d.irq_mask = pwdata[1:0];
        default: ;
      endcase
    end
    // set beats clear on the same edge
    if (lol_set) begin
      s_d.lol = 1'b1; // [RL3]
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    // a set mask bit lets its status bit onto the level irq
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    s_d.rate = s_d.pll_ctrl[RATE_HI:RATE_LO];
    s_d.rate_13g5 = (s_d.rate == RATE_13G5); // [RL2]
    s_d.link_reset = s_d.link_ctrl[LINK_OFF_BIT]; // [RL8]
    // stream path, cleared to zero while link held in reset
    if (s_q.link_ctrl[LINK_OFF_BIT]) begin
      s_d.lane_valid = 1'b0; // [RL8]
      s_d.lane_a = '0;
      s_d.lane_b = '0;
      // test count restarts so the next run begins at zero
      s_d.test_cnt = 14'h0000;
    end else begin
      s_d.lane_valid = sample_valid;
      if (sample_valid) begin
        tl = s_q.link_ctrl[TAIL_PN_BIT] ? pn_bits : TAIL_FIXED; // [RL7]
        a_s = s_q.swap[SWAP_BIT] ? sample_b : sample_a; // [RL1]
        b_s = s_q.swap[SWAP_BIT] ? sample_a : sample_b; // [RL1]
        // long transport pattern: running count, lane b offset by one
        s_d.lane_a = make_word(src, a_s, s_q.test_cnt, tl); // [RL6]
        s_d.lane_b = make_word(src, b_s, s_q.test_cnt + 14'h0001, tl);
        s_d.test_cnt = (src == SRC_TEST) ? s_q.test_cnt + 14'h0002 : 14'h0000;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // rate outputs reset to agree with the pll_ctrl reset value
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.pll_ctrl <= RST_PLL_CTRL;
      s_q.link_ctrl <= RST_LINK_CTRL1;
      s_q.swap <= RST_SWAP;
      s_q.rate <= RST_PLL_CTRL[7:4];
      s_q.rate_13g5 <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // every output comes straight from a state flop
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign lane_a = s_q.lane_a;
  assign lane_b = s_q.lane_b;
  assign lane_valid = s_q.lane_valid;
  assign lane_rate_code = s_q.rate;
  assign rate_13g5_sel = s_q.rate_13g5;
  assign link_reset = s_q.link_reset;
  assign irq = s_q.irq;
endmodule : sltc_top

// ### include/sltc_pkg.sv
package sltc_pkg;
  // ----------------------------------------
  // register map (printed offsets are not multiples of four: index * 4)
  // ----------------------------------------
  localparam logic [11:0] IDX_SWAP = 12'h564;
  localparam logic [11:0] IDX_PLL_CTRL = 12'h56E;
  localparam logic [11:0] IDX_PLL_STAT = 12'h56F;
  localparam logic [11:0] IDX_LINK_CTRL1 = 12'h571;
  localparam logic [11:0] IDX_IRQ_STAT = 12'h600;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h601;
  localparam int ADDR_W = 14;
  localparam logic [13:0] ADDR_SWAP = {IDX_SWAP, 2'b00};
  localparam logic [13:0] ADDR_PLL_CTRL = {IDX_PLL_CTRL, 2'b00};
  localparam logic [13:0] ADDR_PLL_STAT = {IDX_PLL_STAT, 2'b00};
  localparam logic [13:0] ADDR_LINK_CTRL1 = {IDX_LINK_CTRL1, 2'b00};
  localparam logic [13:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [13:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // ----------------------------------------
  // field positions and values
  // ----------------------------------------
  localparam int SWAP_BIT = 0;
  localparam int RATE_HI = 7;
  localparam int RATE_LO = 4;
  localparam int LOCK_BIT = 7;
  localparam int LOL_BIT = 3;
  localparam int STBY_SEL_BIT = 7;
  localparam int TAIL_PN_BIT = 6;
  localparam int LTPL_BIT = 5;
  localparam int LINK_OFF_BIT = 0;
  localparam logic [3:0] RATE_13G5 = 4'h3;
  localparam logic [7:0] RST_PLL_CTRL = 8'h30;
  localparam logic [7:0] RST_LINK_CTRL1 = 8'h00;
  localparam logic [7:0] RST_SWAP = 8'h00;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [15:0] PN_SEED = 16'hACE1;
  localparam logic [1:0] TAIL_FIXED = 2'h0;
  localparam int IRQ_LOL = 0;
  localparam int IRQ_LOCK = 1;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [13:0] sample;
    logic [1:0] tail;
    logic is_k;
  } sltc_word_t;

  typedef enum logic [1:0] {SRC_DATA, SRC_ZERO, SRC_CGS, SRC_TEST} sltc_src_t;
endpackage : sltc_pkg

// ### hdl/sltc_pn.sv
`timescale 1ns/1ps
// ----------------------------------------
// pseudorandom tail bit source
// ----------------------------------------
module sltc_pn
  import sltc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic advance,
  output logic [1:0] bits
);
  import sltc_pkg::*;
  typedef struct packed {
    logic [15:0] lfsr;
  } sltc_pn_st_t;
  sltc_pn_st_t s_q, s_d;

  // two-tap fibonacci step (bits 15 and 13), two bits per sample
  always_comb begin
    s_d = s_q;
    if (advance) begin
      s_d.lfsr = {s_q.lfsr[13:0], s_q.lfsr[15] ^ s_q.lfsr[13], s_q.lfsr[14] ^ s_q.lfsr[12]};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{lfsr: PN_SEED};
    end else begin
      s_q <= s_d;
    end
  end

  assign bits = s_q.lfsr[1:0];
endmodule : sltc_pn

// ### testbench/sltc_sva.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module sltc_sva
  import sltc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire sltc_pkg::sltc_word_t lane_a,
  input wire sltc_pkg::sltc_word_t lane_b,
  input wire logic lane_valid,
  input wire logic [3:0] lane_rate_code,
  input wire logic rate_13g5_sel,
  input wire logic link_reset,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_rate; rate_13g5_sel == (lane_rate_code == RATE_13G5); endproperty
  a_rate: assert property (p_rate) else $error("rate select disagrees with code");
  property p_acc; psel && !penable |=> pready; endproperty
  a_acc: assert property (p_acc) else $error("no answer in access cycle");
  property p_rdz; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("upper read bits set");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_vld; lane_valid |-> $past(sample_valid); endproperty
  a_vld: assert property (p_vld) else $error("lane valid without sample");
  property p_off; link_reset && $past(link_reset) |-> !lane_valid && lane_a == '0 && lane_b == '0; endproperty
  a_off: assert property (p_off) else $error("lanes active in link reset");
  property p_kpair; lane_a.is_k == lane_b.is_k; endproperty
  a_kpair: assert property (p_kpair) else $error("lanes disagree on control char");
  property p_kchar; lane_a.is_k |-> lane_a.sample[7:0] == K28_5; endproperty
  a_kchar: assert property (p_kchar) else $error("wrong control char");
  c_k: cover property (lane_a.is_k);
  c_off: cover property (link_reset);
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule : sltc_sva

bind sltc_top sltc_sva u_sva (.clk_sys, .nrst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .sample_valid, .lane_a, .lane_b, .lane_valid, .lane_rate_code, .rate_13g5_sel, .link_reset, .irq);

// ### testbench/sltc_rx_model.sv
`timescale 1ns/1ps
// ----
// far-end receiver: asks for sync until it sees KCNT control chars in a row
// ----
module sltc_rx_model
  import sltc_pkg::*;
#(
  parameter int KCNT = 4
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire sltc_pkg::sltc_word_t lane_a,
  input wire logic lane_valid,
  output logic receiver_sync_request_input
);
  logic [3:0] kseen_q;
  // idle lanes are ignored so a gap does not break the run
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      kseen_q <= 4'h0;
      receiver_sync_request_input <= 1'b0;
    end else if (!receiver_sync_request_input && lane_valid) begin
      kseen_q <= lane_a.is_k ? kseen_q + 4'h1 : 4'h0;
      if (lane_a.is_k && kseen_q == 4'(KCNT - 1)) begin
        receiver_sync_request_input <= 1'b1;
      end
    end
  end
endmodule : sltc_rx_model

// ### testbench/sltc_top_test.sv
`timescale 1ns/1ps
module sltc_top_test;
  import sltc_pkg::*;
  typedef struct packed {logic [7:0] ctl; logic sw; logic sb; logic [13:0] ea; logic [13:0] eb; logic k;} sltc_row_t;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, lane_valid, rate_13g5_sel;
  logic sample_valid = 1, standby = 0, pll_locked_pin = 1, sync_req, link_reset, irq;
  logic [13:0] paddr = 0, sample_a = 14'h1234, sample_b = 14'h0ABC, x, y;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] lane_rate_code;
  logic [1:0] tacc;
  sltc_word_t lane_a, lane_b;
  int n_errors = 0, cmp_count = 0;
  sltc_row_t rows [5] = '{'{8'h00, 1'b0, 1'b0, 14'h1234, 14'h0ABC, 1'b0}, '{8'h00, 1'b1, 1'b0, 14'h0ABC, 14'h1234, 1'b0},
    '{8'h00, 1'b0, 1'b1, 14'h0, 14'h0, 1'b0}, '{8'h80, 1'b0, 1'b1, 14'h00BC, 14'h00BC, 1'b1},
    '{8'h80, 1'b1, 1'b0, 14'h0ABC, 14'h1234, 1'b0}};
  sltc_top dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_a,
    .sample_b, .sample_valid, .standby, .pll_locked_pin, .receiver_sync_request_input(sync_req), .lane_a, .lane_b,
    .lane_valid, .lane_rate_code, .rate_13g5_sel, .link_reset, .irq);
  sltc_rx_model rx (.clk_sys, .nrst, .lane_a, .lane_valid, .receiver_sync_request_input(sync_req));
  always #4 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; read data and error flag are checked at the answering edge
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [31:0] e, input logic ee);
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    if (!w) chk(prdata, e);
    chk(pslverr, ee);
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : wt
  task automatic stop_test;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // watchdog cuts a hang short
  initial begin
    repeat (8000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    wt(0);
    chk(lane_rate_code, 4'h3);
    chk(link_reset, 1'b0);
    wt(2);
    chk({lane_valid, lane_a.is_k, lane_a.sample}, {2'b11, 6'h00, K28_5});
    apb(0, ADDR_PLL_CTRL, 0, 32'h30, 0);
    apb(0, ADDR_LINK_CTRL1, 0, 32'h0, 0);
    foreach (rows[i]) begin
      apb(1, ADDR_SWAP, {31'h0, rows[i].sw}, 0, 0);
      apb(1, ADDR_LINK_CTRL1, {24'h0, rows[i].ctl}, 0, 0);
      standby <= rows[i].sb;
      wt(8);
      chk({lane_valid, lane_a.sample, lane_a.tail, lane_b.sample, lane_a.is_k}, {1'b1, rows[i].ea, 2'h0, rows[i].eb, rows[i].k});
      $display("row %0d done", i);
    end
    standby <= 1'b0;
    apb(1, ADDR_SWAP, 0, 0, 0);
    apb(1, ADDR_PLL_CTRL, 32'h5F, 0, 0);
    apb(0, ADDR_PLL_CTRL, 0, 32'h50, 0);
    wt(3);
    chk({lane_rate_code, rate_13g5_sel}, 5'h0A);
    apb(1, ADDR_LINK_CTRL1, 32'h20, 0, 0);
    wt(6);
    x = lane_a.sample;
    y = x + 14'h1;
    chk(lane_b.sample, y);
    wt(0);
    y = x + 14'h2;
    chk(lane_a.sample, y);
    apb(1, ADDR_LINK_CTRL1, 32'h40, 0, 0);
    tacc = 2'h0;
    repeat (12) begin
      wt(0);
      tacc = tacc | lane_a.tail;
    end
    chk(tacc != 2'h0, 1'b1);
    $display("test and tail done");
    apb(1, ADDR_LINK_CTRL1, 0, 0, 0);
    apb(1, ADDR_IRQ_STAT, 32'h3, 0, 0);
    apb(1, ADDR_IRQ_MASK, 32'h3, 0, 0);
    wt(2);
    chk(irq, 1'b0);
    @(posedge clk_sys) pll_locked_pin <= 1'b0;
    wt(6);
    chk(irq, 1'b1);
    apb(0, ADDR_IRQ_STAT, 0, 32'h1, 0);
    apb(1, ADDR_IRQ_MASK, 0, 0, 0);
    wt(3);
    chk(irq, 1'b0);
    @(posedge clk_sys) pll_locked_pin <= 1'b1;
    wt(6);
    apb(0, ADDR_PLL_STAT, 0, 32'h88, 0);
    apb(1, ADDR_LINK_CTRL1, 32'h1, 0, 0);
    wt(4);
    chk({link_reset, lane_valid}, 2'b10);
    apb(0, ADDR_PLL_STAT, 0, 32'h80, 0);
    apb(1, ADDR_LINK_CTRL1, 0, 0, 0);
    wt(4);
    chk({link_reset, lane_valid}, 2'b01);
    apb(0, 14'h0, 0, 32'h0, 1);
    $display("status and link done");
    @(posedge clk_sys) sample_valid <= 1'b0;
    wt(2);
    chk(lane_valid, 1'b0);
    @(posedge clk_sys) sample_valid <= 1'b1;
    @(posedge clk_sys) nrst <= 1'b0;
    wt(2);
    chk({lane_rate_code, rate_13g5_sel, link_reset, irq, lane_valid}, {RATE_13G5, 4'b1000});
    @(posedge clk_sys) nrst <= 1'b1;
    apb(0, ADDR_PLL_CTRL, 0, {24'h0, RST_PLL_CTRL}, 0);
    wt(2);
    chk({lane_valid, lane_a.is_k}, 2'b11);
    $display("reset done");
    stop_test();
  end
endmodule : sltc_top_test
